/* File: rtl/sipo_map.vh */
// Overview of operation
// - eight-bit shift register feeds an eight-bit storage register of equal width
// - each storage bit has its own parallel output that can float
// - shift and storage registers clocked by two separate clock inputs
// - low shift clear empties every shift stage, overriding shifting
// - serial cascade output lets several devices chain
// - output enable high floats parallel outputs; cascade output always driven
// - shift and store on rising edges of shift clock and storage clock; low shift clear acts without an edge
// - with clocks tied, storage captures shift contents from before the edge
// - shift edge with clear high loads first stage from serial input
// - same edge loads each later stage from its predecessor's old value
// - each storage clock rising edge copies all eight stages in parallel
`ifndef SIPO_MAP_VH
`define SIPO_MAP_VH
`define SIPO_WIDTH      8
`define SIPO_SHIFT_RST  8'h00
`define SIPO_STORE_RST  8'h00
`define SIPO_LAST_BIT   7
`endif

/* File: rtl/sipo_edge.v */
`timescale 1ns/1ps
// rising edge detector on a clock-synchronous input
module sipo_edge (
    // system
    input  wire clk,
    input  wire rstn,
    // level in, pulse out
    input  wire level_in,
    output wire rise
);
    reg level_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_in;
        end
    end

    assign rise = level_in & ~level_q;
endmodule

/* File: rtl/sipo_store.v */
`timescale 1ns/1ps
`include "sipo_map.vh"
// storage register with floatable parallel outputs
module sipo_store #(
    parameter WIDTH = `SIPO_WIDTH
) (
    // system
    input  wire             clk,
    input  wire             rstn,
    // capture
    input  wire             capture,
    input  wire [WIDTH-1:0] shift_val,
    // parallel pins
    input  wire             output_enable_n,
    output wire [WIDTH-1:0] parallel_out,
    output wire [WIDTH-1:0] parallel_oe_n
);
    reg [WIDTH-1:0] store_q;

    // old shift value is taken, so tied clocks lag by one shift
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            store_q <= `SIPO_STORE_RST;
        end else if (capture) begin
            store_q <= shift_val;
        end
    end

    assign parallel_out  = store_q;
    assign parallel_oe_n = {WIDTH{output_enable_n}};
endmodule

/* File: rtl/sipo_top.v */
`timescale 1ns/1ps
`include "sipo_map.vh"
// serial-in parallel-out latch; pin clocks sampled by the system clock
module sipo_top #(
    parameter WIDTH = `SIPO_WIDTH
) (
    // system
    input  wire             clk,
    input  wire             rstn,
    // serial side
    input  wire             serial_in,
    input  wire             shift_clock,
    input  wire             shift_clear_n,
    output wire             cascade_out,
    // storage side
    input  wire             storage_clock,
    input  wire             output_enable_n,
    output wire [WIDTH-1:0] parallel_out,
    output wire [WIDTH-1:0] parallel_oe_n
);

    // shift stage reset image, one bit per stage
    localparam [WIDTH-1:0] SHIFT_RST = `SIPO_SHIFT_RST;

    // what every shift stage does on this clock
    localparam [1:0] ACT_HOLD  = 2'b00;
    localparam [1:0] ACT_SHIFT = 2'b01;
    localparam [1:0] ACT_CLEAR = 2'b10;

    // pin edges seen by the system clock
    wire             shift_rise;
    wire             store_rise;

    // stage action for this clock
    reg  [1:0]       shift_act;

    // value each stage would take on a shift
    wire [WIDTH-1:0] shift_feed;

    // next and present stage contents
    wire [WIDTH-1:0] shift_d;
    wire [WIDTH-1:0] shift_bits;

    // generate index, reused by every loop below
    genvar           g;

    // a clear outranks a shift edge in the same clock
    function [1:0] act_of;
        input clear_n;
        input rise;
        begin
            if (!clear_n) begin
                act_of = ACT_CLEAR;
            end else if (rise) begin
                act_of = ACT_SHIFT;
            end else begin
                act_of = ACT_HOLD;
            end
        end
    endfunction

    // one stage's next value for a given action
    function stage_next;
        input [1:0] act;
        input       old_bit;
        input       feed_bit;
        input       clear_bit;
        begin
            case (act)
                ACT_CLEAR: begin
                    stage_next = clear_bit;
                end
                ACT_SHIFT: begin
                    stage_next = feed_bit;
                end
                ACT_HOLD: begin
                    stage_next = old_bit;
                end
                default: begin
                    stage_next = old_bit;
                end
            endcase
        end
    endfunction

    // each pin has its own detector, so the two clocks stay independent
    sipo_edge u_shift_edge (
        .clk      (clk),
        .rstn     (rstn),
        .level_in (shift_clock),
        .rise     (shift_rise)
    );

    sipo_edge u_store_edge (
        .clk      (clk),
        .rstn     (rstn),
        .level_in (storage_clock),
        .rise     (store_rise)
    );

    // one action for all stages; the clear needs no edge
    always @* begin
        shift_act = act_of(shift_clear_n, shift_rise);
    end

    // stage 0 listens to the serial pin, the rest to their neighbour
    assign shift_feed[0] = serial_in;

    generate
        for (g = 1; g < WIDTH; g = g + 1) begin : g_feed
            assign shift_feed[g] = shift_bits[g-1];
        end
    endgenerate

    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_stage
            reg stage_q;

            assign shift_d[g] = stage_next(shift_act,
                                           stage_q,
                                           shift_feed[g],
                                           SHIFT_RST[g]);

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    stage_q <= SHIFT_RST[g];
                end else begin
                    stage_q <= shift_d[g];
                end
            end

            assign shift_bits[g] = stage_q;
        end
    endgenerate

    // cascade follows the last stage, so a clear drops it on the next system clock
    assign cascade_out = shift_bits[WIDTH-1];

    // host must space storage edge after last shift edge
    sipo_store #(
        .WIDTH (WIDTH)
    ) u_store (
        .clk             (clk),
        .rstn            (rstn),
        .capture         (store_rise),
        .shift_val       (shift_bits),
        .output_enable_n (output_enable_n),
        .parallel_out    (parallel_out),
        .parallel_oe_n   (parallel_oe_n)
    );
endmodule

/* File: verif/sipo_props.sv */
`timescale 1ns/1ps
module sipo_props #(parameter WIDTH = 8) (
    input wire             clk,
    input wire             rstn,
    input wire             shift_clock,
    input wire             shift_clear_n,
    input wire             cascade_out,
    input wire             storage_clock,
    input wire             output_enable_n,
    input wire [WIDTH-1:0] parallel_out,
    input wire [WIDTH-1:0] parallel_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    clear_tail_a: assert property
        (!shift_clear_n |=> !cascade_out) else $error("clear");
    store_tail_a: assert property
        ($rose(storage_clock) |=> parallel_out[WIDTH-1] == $past(cascade_out))
        else $error("lag");
    shift_hold_a: assert property
        (shift_clear_n && !$rose(shift_clock) |=> $stable(cascade_out))
        else $error("cascade moved without a shift edge");
    store_hold_a: assert property
        (!$rose(storage_clock) |=> $stable(parallel_out))
        else $error("storage moved without a storage edge");
    clear_keep_a: assert property
        (!shift_clear_n && !$rose(storage_clock) |=> $stable(parallel_out))
        else $error("clear disturbed storage");
    oe_mirror_a: assert property
        (parallel_oe_n == {WIDTH{output_enable_n}})
        else $error("output enable not mirrored");
endmodule
bind sipo_top sipo_props #(.WIDTH(WIDTH)) i_sipo_props (.*);

/* File: verif/sipo_host.sv */
`timescale 1ns/1ps
module sipo_host (
    input wire clk,
    output reg serial_in = 0, shift_clock = 0, storage_clock = 0,
    output reg shift_clear_n = 1
);
    task tick; @(posedge clk); #1; endtask
    task store; storage_clock = 1; tick; storage_clock = 0; tick; endtask
    // clear lands together with a shift edge carrying a one
    task clear; shift_clear_n = 0; serial_in = 1; shift_clock = 1; tick;
        shift_clear_n = 1; shift_clock = 0; tick; endtask
    // both clocks from one edge
    task tied(input b); serial_in = b; shift_clock = 1; storage_clock = 1;
        tick; shift_clock = 0; storage_clock = 0; tick; endtask
    task send(input [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            serial_in = d[i]; shift_clock = 1; tick; shift_clock = 0; tick;
        end endtask
endmodule

/* File: verif/sipo_top_bench.sv */
`timescale 1ns/1ps
module sipo_top_bench;
    reg clk = 0, rstn = 0, output_enable_n = 0;
    wire serial_in, shift_clock, shift_clear_n, storage_clock, cascade_out;
    wire [7:0] parallel_out, parallel_oe_n;
    reg [7:0] q[$], d;
    integer mismatches = 0, n_tests = 0, seed = 55, r;
    initial forever #5 clk = ~clk;
    sipo_top i_sipo_top (.*);
    sipo_host i_sipo_host (.*);
    task chk(input [7:0] s, e); n_tests++;
        if (s !== e) begin mismatches++; $display("MISMATCH %0t %h %h",
            $time, s, e); end endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (!mismatches && n_tests) $display("All tests passed");
        else $display("Some tests failed");
        $finish; endtask
    always @(posedge storage_clock) begin
        @(posedge clk) #2;
        if (q.size() == 0) chk(parallel_out, ~parallel_out);
        else chk(parallel_out, q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clk); #1 rstn = 1;
        repeat (6) begin
            r = $random(seed); d = r[7:0]; output_enable_n = d[0];
            q.push_back(d); i_sipo_host.send(d);
            chk({7'h00, cascade_out}, {7'h00, d[7]});
            i_sipo_host.store;
            chk(parallel_oe_n, {8{d[0]}});
        end
        r = $random(seed); q.push_back(d); q.push_back({d[6:0], r[0]});
        i_sipo_host.tied(r[0]);
        i_sipo_host.store;
        i_sipo_host.clear;
        chk({7'h00, cascade_out}, 8'h00);
        chk(parallel_out, {d[6:0], r[0]});
        q.push_back(8'h00); i_sipo_host.store;
        rstn = 0; @(posedge clk); #1 rstn = 1;
        r = $random(seed); d = r[7:0]; q.push_back(d);
        i_sipo_host.send(d); i_sipo_host.store;
        chk({7'h00, q.size() == 0}, 8'h01);
        test_done;
    end
endmodule
